// File: design/sees_serial_slave.sv
// Notes on behaviour
// - Watchdog select bits pick timeout or disable.
// - Writing 02H with register latch clear sets write latch, no busy.
// - Writing 06H with write latch set sets both latches, no busy.
// - Third byte starts nonvolatile store, busy.
// - Store clears register latch unless bit2 set.
// - Second control data byte aborts with NACK.
// - Reads between steps keep latch states.
// - Register latch cleared only by store, protect hit.
// - Start and stop seen while clock high.
// - Ignore everything until a start.
// - Stop returns device to standby.
// - Acknowledge matching slave, address, data bytes.
// - Send array bytes while master acknowledges.
// - Slave byte: type, zeros, address msb, direction.
// - Power-up standby, latch clear, pin released.
// - Address counter resets to zero until first load.
// - Byte write stop starts nonvolatile cycle.
// - Busy cycle ignores bus, releases data pin.
// - No acknowledge for data into protected block.
// - Page write increments low four address bits.
// - Extra page bytes overwrite; stop commits page.
// - Latch clear ignores writes, NACKs data except 02H.
// - Control register at 1FFh, one byte each.
// - Early stop performs no write.
`timescale 1ns/1ps
module sees_serial_slave
  import sees_pkg::*;
#(
  parameter int unsigned P_WD_LONG_CYCLES  = WD_LONG_CYC,
  parameter int unsigned P_WD_MID_CYCLES   = WD_MID_CYC,
  parameter int unsigned P_WD_SHORT_CYCLES = WD_SHORT_CYC,
  parameter int unsigned P_NV_WRITE_CYCLES = NV_WRITE_CYC,
  parameter int unsigned P_POR_HOLD_CYCLES = POR_HOLD_CYC
)(
  input  logic        i_mclk,
  input  logic        i_rst_n,
  input  logic        i_scl,
  input  logic        i_sda,
  output logic        o_sda_out,
  output logic        o_sda_oe,
  output logic        o_watchdog_enable,
  output logic [23:0] o_watchdog_timeout_cycles,
  output logic        o_power_on_reset,
  output logic        o_busy
);

  function automatic logic is_protected(input logic [8:0] a, input logic [2:0] bp);
    logic r;
    r = 1'b0;
    unique case (bp)
      3'b000: r = 1'b0;
      3'b001: r = (a >= PROT_UPPER_QTR);
      3'b010: r = (a >= PROT_UPPER_HALF);
      3'b011: r = 1'b1;
      3'b100: r = (a <= PROT_PAGE1_END);
      3'b101: r = (a <= PROT_PAGE2_END);
      3'b110: r = (a <= PROT_PAGE4_END);
      3'b111: r = (a <= PROT_PAGE8_END);
    endcase
    return r;
  endfunction

  sees_bus_s   bus;
  sees_state_e state;
  sees_kind_e  kind;
  sees_ctrl_s  ctrl;
  logic [3:0]  bit_cnt;
  logic [7:0]  rx_sh;
  logic [7:0]  tx_sh;
  logic [7:0]  ctrl_byte;
  logic [8:0]  addr;
  logic        drive_low;
  logic        sel_ctrl;
  logic        rd_mode;
  logic        addr_msb;
  logic        m_ack;
  logic        have_data;
  logic        abort;
  logic [23:0] busy_cnt;
  logic [23:0] por_cnt;
  logic [7:0]  mem [MEM_DEPTH];
  logic [7:0]  pbuf [PAGE_SIZE];
  logic [PAGE_SIZE-1:0] pvalid;

  logic ev_start;
  logic ev_stop;
  logic byte_end;
  logic ack_ok;
  logic buf_we;
  logic prot_hit;
  logic lat_only;
  logic nv_store;
  logic wr_done;
  logic commit;
  logic ctrl_apply;
  logic busy_done;

  sees_pin_sync u_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_scl   (i_scl),
    .i_sda   (i_sda),
    .o_bus   (bus)
  );

  // Bus events are dropped entirely while the store runs
  assign ev_start  = bus.start && state != ST_BUSY;
  assign ev_stop   = bus.stop && state != ST_BUSY;
  assign byte_end  = state == ST_RX && bus.scl_fall && bit_cnt == BITS_PER_BYTE;
  assign busy_done = state == ST_BUSY && busy_cnt == 24'h00_0000;

  always_comb begin
    ack_ok   = 1'b0;
    buf_we   = 1'b0;
    prot_hit = 1'b0;
    unique case (kind)
      KIND_SLAVE: begin
        ack_ok = rx_sh[7:5] == TYPE_PREFIX && rx_sh[3:2] == 2'b00;
      end
      KIND_WORD: begin
        ack_ok = 1'b1;
      end
      KIND_DATA: begin
        if (sel_ctrl) begin
          // 02H must pass with the latch clear, or it could never be set
          ack_ok = (ctrl.write_enable_latch || rx_sh == CMD_SET_WEL)
                   && !have_data && !abort
                   && addr == CTRL_ADDR;
        end else if (ctrl.write_enable_latch) begin
          prot_hit = is_protected(addr, {ctrl.block_protect_sel_2,
                                         ctrl.block_protect_sel_1,
                                         ctrl.block_protect_sel_0});
          buf_we   = !prot_hit;
          ack_ok   = !prot_hit;
        end
      end
      default: ack_ok = 1'b0;
    endcase
  end

  // 06H always reads as the second step, so a repeat leaves the stored bits
  assign lat_only = ctrl_byte == CMD_SET_BOTH || ctrl_byte == CMD_CLR_WEL
                    || (ctrl_byte == CMD_SET_WEL && !ctrl.register_write_enable_latch);
  assign nv_store = !lat_only && !ctrl_byte[7] && ctrl_byte[1]
                    && ctrl.write_enable_latch
                    && ctrl.register_write_enable_latch;
  assign wr_done    = ev_stop && kind == KIND_DATA && !rd_mode && have_data && !abort;
  assign ctrl_apply = wr_done && sel_ctrl;
  assign commit     = wr_done && (!sel_ctrl || nv_store);

  // Serial engine
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state     <= ST_IDLE;
      kind      <= KIND_SLAVE;
      bit_cnt   <= 4'h0;
      rx_sh     <= 8'h00;
      tx_sh     <= 8'h00;
      ctrl_byte <= 8'h00;
      addr      <= 9'h000;
      drive_low <= 1'b0;
      sel_ctrl  <= 1'b0;
      rd_mode   <= 1'b0;
      addr_msb  <= 1'b0;
      m_ack     <= 1'b0;
      have_data <= 1'b0;
      abort     <= 1'b0;
    end else if (state == ST_BUSY) begin
      if (busy_done) begin
        state <= ST_IDLE;
      end
    end else if (ev_start) begin
      state     <= ST_RX;
      kind      <= KIND_SLAVE;
      bit_cnt   <= 4'h0;
      drive_low <= 1'b0;
      have_data <= 1'b0;
      abort     <= 1'b0;
    end else if (ev_stop) begin
      drive_low <= 1'b0;
      // A stop whose start fell in the busy time must not apply again
      have_data <= 1'b0;
      state     <= commit ? ST_BUSY : ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          drive_low <= 1'b0;
        end
        ST_RX: begin
          if (bus.scl_rise) begin
            rx_sh   <= {rx_sh[6:0], bus.sda};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_end) begin
            state     <= ST_ACK;
            bit_cnt   <= 4'h0;
            drive_low <= ack_ok;
            unique case (kind)
              KIND_SLAVE: begin
                sel_ctrl <= rx_sh[TYPE_SEL_BIT];
                rd_mode  <= rx_sh[DIR_BIT];
                addr_msb <= rx_sh[ADDR_MSB_BIT];
              end
              KIND_WORD: begin
                addr <= {addr_msb, rx_sh};
              end
              KIND_DATA: begin
                if (sel_ctrl) begin
                  if (have_data) begin
                    abort <= 1'b1;
                  end else begin
                    ctrl_byte <= rx_sh;
                  end
                end else if (buf_we) begin
                  addr[3:0] <= addr[3:0] + 4'h1;
                end
              end
              default: abort <= 1'b1;
            endcase
          end
        end
        ST_ACK: begin
          if (bus.scl_fall) begin
            drive_low <= 1'b0;
            bit_cnt   <= 4'h0;
            if (!drive_low) begin
              state <= ST_IDLE;
            end else if (kind == KIND_SLAVE && rd_mode) begin
              state     <= ST_TX;
              tx_sh     <= sel_ctrl ? ctrl : mem[addr];
              drive_low <= sel_ctrl ? ~ctrl[7] : ~mem[addr][7];
              if (!sel_ctrl) begin
                addr <= addr + 9'h001;
              end
            end else begin
              state <= ST_RX;
              if (kind == KIND_DATA) begin
                have_data <= 1'b1;
              end
              kind <= (kind == KIND_SLAVE) ? KIND_WORD : KIND_DATA;
            end
          end
        end
        ST_TX: begin
          if (bus.scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end else if (bus.scl_fall) begin
            if (bit_cnt == BITS_PER_BYTE) begin
              drive_low <= 1'b0;
              state     <= ST_RACK;
              m_ack     <= 1'b0;
            end else begin
              tx_sh     <= {tx_sh[6:0], 1'b0};
              drive_low <= ~tx_sh[6];
            end
          end
        end
        ST_RACK: begin
          if (bus.scl_rise) begin
            m_ack <= ~bus.sda;
          end else if (bus.scl_fall) begin
            bit_cnt <= 4'h0;
            // One byte per control read; the array read runs on and wraps
            if (m_ack && !sel_ctrl) begin
              state     <= ST_TX;
              tx_sh     <= mem[addr];
              drive_low <= ~mem[addr][7];
              addr      <= addr + 9'h001;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Store timer
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_cnt <= 24'h00_0000;
    end else if (commit) begin
      busy_cnt <= 24'(P_NV_WRITE_CYCLES - 1);
    end else if (state == ST_BUSY && busy_cnt != 24'h00_0000) begin
      busy_cnt <= busy_cnt - 24'h00_0001;
    end
  end

  // Control latches; reads never touch them
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl <= CTRL_RESET;
    end else if (byte_end && prot_hit) begin
      ctrl.register_write_enable_latch <= 1'b0;
    end else if (ctrl_apply) begin
      if (nv_store) begin
        ctrl.watchdog_period_sel_high    <= ctrl_byte[6];
        ctrl.watchdog_period_sel_low     <= ctrl_byte[5];
        ctrl.block_protect_sel_1         <= ctrl_byte[4];
        ctrl.block_protect_sel_0         <= ctrl_byte[3];
        ctrl.block_protect_sel_2         <= ctrl_byte[0];
        ctrl.register_write_enable_latch <= ctrl_byte[2];
      end else if (ctrl_byte == CMD_SET_BOTH) begin
        ctrl.write_enable_latch          <= 1'b1;
        ctrl.register_write_enable_latch <= 1'b1;
      end else if (ctrl_byte == CMD_SET_WEL) begin
        ctrl.write_enable_latch <= 1'b1;
      end else if (ctrl_byte == CMD_CLR_WEL) begin
        ctrl.write_enable_latch <= 1'b0;
      end
    end
  end

  // Page buffer; a start discards anything left from an unfinished load
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pvalid <= '0;
      for (int i = 0; i < PAGE_SIZE; i++) begin
        pbuf[i] <= 8'h00;
      end
    end else if (ev_start) begin
      pvalid <= '0;
    end else if (byte_end && buf_we) begin
      pbuf[addr[3:0]]   <= rx_sh;
      pvalid[addr[3:0]] <= 1'b1;
    end
  end

  // Array
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem[i] <= MEM_ERASED;
      end
    end else if (commit && !sel_ctrl) begin
      for (int i = 0; i < PAGE_SIZE; i++) begin
        if (pvalid[i]) begin
          mem[{addr[8:4], 4'(i)}] <= pbuf[i];
        end
      end
    end
  end

  // Watchdog period out
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_watchdog_enable         <= 1'b0;
      o_watchdog_timeout_cycles <= 24'h00_0000;
    end else begin
      unique case ({ctrl.watchdog_period_sel_high, ctrl.watchdog_period_sel_low})
        2'b00: o_watchdog_timeout_cycles <= 24'(P_WD_LONG_CYCLES);
        2'b01: o_watchdog_timeout_cycles <= 24'(P_WD_MID_CYCLES);
        2'b10: o_watchdog_timeout_cycles <= 24'(P_WD_SHORT_CYCLES);
        2'b11: o_watchdog_timeout_cycles <= 24'h00_0000;
      endcase
      o_watchdog_enable <= !(ctrl.watchdog_period_sel_high
                             && ctrl.watchdog_period_sel_low);
    end
  end

  // Power-on reset hold
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      por_cnt          <= 24'h00_0000;
      o_power_on_reset <= 1'b1;
    end else if (por_cnt != 24'(P_POR_HOLD_CYCLES)) begin
      por_cnt <= por_cnt + 24'h00_0001;
    end else begin
      o_power_on_reset <= 1'b0;
    end
  end

  assign o_sda_out = 1'b0;
  assign o_sda_oe  = drive_low && state != ST_BUSY;
  assign o_busy    = state == ST_BUSY;

endmodule

// File: design/sees_pkg.sv
package sees_pkg;

  // Clock and timing
  localparam int CLK_HZ      = 10_000_000;
  localparam int CLK_PER_MS  = CLK_HZ / 1000;
  localparam int WD_LONG_MS  = 1400;
  localparam int WD_MID_MS   = 600;
  localparam int WD_SHORT_MS = 200;
  localparam int NV_WRITE_MS = 10;
  localparam int WD_LONG_CYC  = WD_LONG_MS * CLK_PER_MS;
  localparam int WD_MID_CYC   = WD_MID_MS * CLK_PER_MS;
  localparam int WD_SHORT_CYC = WD_SHORT_MS * CLK_PER_MS;
  localparam int NV_WRITE_CYC = NV_WRITE_MS * CLK_PER_MS;
  // No figure is given for the power-on hold; plain default
  localparam int POR_HOLD_CYC = 32'h0000_03E8;

  // Sizes
  localparam int MEM_DEPTH = 32'h0000_0200;
  localparam int PAGE_SIZE = 32'h0000_0010;

  // Slave byte layout: type[7:4], zeros[3:2], msb[1], dir[0]
  localparam logic [2:0] TYPE_PREFIX   = 3'h5;
  localparam int         TYPE_SEL_BIT  = 4;
  localparam int         ADDR_MSB_BIT  = 1;
  localparam int         DIR_BIT       = 0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Control register
  localparam logic [8:0] CTRL_ADDR    = 9'h1FF;
  localparam logic [7:0] CMD_SET_WEL  = 8'h02;
  localparam logic [7:0] CMD_SET_BOTH = 8'h06;
  localparam logic [7:0] CMD_CLR_WEL  = 8'h00;

  // Protection boundaries
  localparam logic [8:0] PROT_UPPER_QTR  = 9'h180;
  localparam logic [8:0] PROT_UPPER_HALF = 9'h100;
  localparam logic [8:0] PROT_PAGE1_END  = 9'h00F;
  localparam logic [8:0] PROT_PAGE2_END  = 9'h01F;
  localparam logic [8:0] PROT_PAGE4_END  = 9'h03F;
  localparam logic [8:0] PROT_PAGE8_END  = 9'h07F;

  typedef struct packed {
    logic zero;
    logic watchdog_period_sel_high;
    logic watchdog_period_sel_low;
    logic block_protect_sel_1;
    logic block_protect_sel_0;
    logic register_write_enable_latch;
    logic write_enable_latch;
    logic block_protect_sel_2;
  } sees_ctrl_s;

  localparam sees_ctrl_s CTRL_RESET = 8'h60;
  localparam logic [7:0] MEM_ERASED = 8'hFF;

  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } sees_bus_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX   = 3'b001,
    ST_ACK  = 3'b010,
    ST_TX   = 3'b011,
    ST_RACK = 3'b100,
    ST_BUSY = 3'b101
  } sees_state_e;

  typedef enum logic [1:0] {
    KIND_SLAVE = 2'b00,
    KIND_WORD  = 2'b01,
    KIND_DATA  = 2'b10
  } sees_kind_e;

endpackage

// File: design/sees_pin_sync.sv
`timescale 1ns/1ps
module sees_pin_sync
  import sees_pkg::*;
(
  input  logic      i_mclk,
  input  logic      i_rst_n,
  input  logic      i_scl,
  input  logic      i_sda,
  output sees_bus_s o_bus
);

  logic [2:0] scl_q;
  logic [2:0] sda_q;

  // Idle bus is high on both lines
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= {scl_q[1:0], i_scl};
      sda_q <= {sda_q[1:0], i_sda};
    end
  end

  always_comb begin
    o_bus.scl      = scl_q[1];
    o_bus.sda      = sda_q[1];
    o_bus.scl_rise = scl_q[1] & ~scl_q[2];
    o_bus.scl_fall = ~scl_q[1] & scl_q[2];
    o_bus.start    = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
    o_bus.stop     = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
  end

endmodule

// File: bench/sees_bus_master.sv
`timescale 1ns/1ps
module sees_bus_master (
  input  logic i_mclk,
  input  logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  // Both lines idle high; o_sda high means released to the pull-up
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // Quarter of an 800 ns bus clock
  task automatic q;
    repeat (2) @(posedge i_mclk);
    #5;
  endtask
  task automatic sta;
    o_sda = 1'b1;
    q;
    o_scl = 1'b1;
    q;
    o_sda = 1'b0;
    q;
    o_scl = 1'b0;
    q;
  endtask
  task automatic sto;
    o_sda = 1'b0;
    q;
    o_scl = 1'b1;
    q;
    o_sda = 1'b1;
    q;
  endtask
  task automatic bt(input logic b, output logic r);
    o_sda = b;
    q;
    o_scl = 1'b1;
    q;
    r = i_sda;
    q;
    o_scl = 1'b0;
    q;
  endtask
  task automatic wb(input logic [7:0] d, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) bt(d[i], r);
    bt(1'b1, r);
    a = !r;
  endtask
  task automatic rb(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bt(1'b1, d[i]);
    bt(!ack, r);
  endtask
endmodule

// File: bench/sees_serial_slave_sva.sv
`timescale 1ns/1ps
module sees_serial_slave_sva
  import sees_pkg::*;
#(
  parameter int unsigned P_WD_LONG_CYCLES  = WD_LONG_CYC,
  parameter int unsigned P_WD_MID_CYCLES   = WD_MID_CYC,
  parameter int unsigned P_WD_SHORT_CYCLES = WD_SHORT_CYC,
  parameter int unsigned P_NV_WRITE_CYCLES = NV_WRITE_CYC,
  parameter int unsigned P_POR_HOLD_CYCLES = POR_HOLD_CYC
)(
  input logic        i_mclk,
  input logic        i_rst_n,
  input logic        i_scl,
  input logic        i_sda,
  input logic        o_sda_out,
  input logic        o_sda_oe,
  input logic        o_watchdog_enable,
  input logic [23:0] o_watchdog_timeout_cycles,
  input logic        o_power_on_reset,
  input logic        o_busy
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  int unsigned busy_n;
  int unsigned por_n;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) busy_n <= 0;
    else busy_n <= o_busy ? busy_n + 1 : 0;
  end
  // Saturates so a long run cannot wrap it
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) por_n <= 0;
    else if (por_n <= P_POR_HOLD_CYCLES) por_n <= por_n + 1;
  end
  a_wd_code: assert property (!o_watchdog_enable ? o_watchdog_timeout_cycles == 24'h00_0000 :
    o_watchdog_timeout_cycles inside {24'(P_WD_LONG_CYCLES), 24'(P_WD_MID_CYCLES),
    24'(P_WD_SHORT_CYCLES)}) else $error("watchdog timeout code mismatch");
  a_wd_shipped: assert property (por_n == 0 |-> !o_watchdog_enable)
    else $error("watchdog enabled at power-up");
  a_sda_open: assert property (o_sda_out == 1'b0)
    else $error("data pin output not low");
  a_busy_quiet: assert property (o_busy |-> !o_sda_oe)
    else $error("data pin driven while busy");
  a_busy_len: assert property ($fell(o_busy) |-> busy_n == P_NV_WRITE_CYCLES)
    else $error("store cycle length wrong");
  a_busy_stop: assert property ($rose(o_busy) |-> i_scl && i_sda)
    else $error("store began without stop");
  a_oe_clk_low: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data pin changed while clock high");
  a_oe_hold: assert property ($rose(i_scl) |=> $stable(o_sda_oe) [*3])
    else $error("data pin unstable in clock high");
  a_por_hold: assert property (o_power_on_reset == (por_n <= P_POR_HOLD_CYCLES))
    else $error("power-on reset length wrong");
  c_store: cover property ($fell(o_busy));
  c_ack: cover property ($rose(o_sda_oe));
  c_wd_on: cover property ($rose(o_watchdog_enable));
endmodule

bind sees_serial_slave sees_serial_slave_sva #(
  .P_WD_LONG_CYCLES (P_WD_LONG_CYCLES),
  .P_WD_MID_CYCLES  (P_WD_MID_CYCLES),
  .P_WD_SHORT_CYCLES(P_WD_SHORT_CYCLES),
  .P_NV_WRITE_CYCLES(P_NV_WRITE_CYCLES),
  .P_POR_HOLD_CYCLES(P_POR_HOLD_CYCLES)
) u_sva (.i_mclk, .i_rst_n, .i_scl, .i_sda, .o_sda_out, .o_sda_oe, .o_watchdog_enable,
  .o_watchdog_timeout_cycles, .o_power_on_reset, .o_busy);

// File: bench/sees_serial_slave_bench.sv
`timescale 1ns/1ps
module sees_serial_slave_bench;
  import sees_pkg::*;
  localparam int unsigned WL = 1400;
  localparam int unsigned WM = 600;
  localparam int unsigned WS = 200;
  logic        i_mclk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        scl;
  logic        sda_m;
  logic        sda;
  logic        o_sda_oe;
  logic        wd_en;
  logic [23:0] wd_cyc;
  logic        o_busy;
  int          n_fail = 0;
  int          comparisons = 0;
  int          cyc = 0;
  logic [7:0]  mem [512];
  logic [7:0]  dq [$];
  logic [7:0]  rq [16];
  logic        a;
  // Pull-up: low when either side pulls
  assign sda = sda_m & ~o_sda_oe;
  always #50 i_mclk = ~i_mclk;
  sees_serial_slave #(.P_NV_WRITE_CYCLES(20), .P_POR_HOLD_CYCLES(10),
    .P_WD_LONG_CYCLES(WL), .P_WD_MID_CYCLES(WM), .P_WD_SHORT_CYCLES(WS)
  ) i_sees_serial_slave (.i_mclk, .i_rst_n, .i_scl(scl), .i_sda(sda), .o_sda_out(),
    .o_sda_oe, .o_watchdog_enable(wd_en), .o_watchdog_timeout_cycles(wd_cyc),
    .o_power_on_reset(), .o_busy);
  sees_bus_master m (.i_mclk, .i_sda(sda), .o_scl(scl), .o_sda(sda_m));
  task automatic wrap_up;
    if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      wrap_up;
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, s);
      n_fail++;
    end
  endtask
  function automatic logic [7:0] slv(input logic c, input logic [8:0] ad, input logic rw);
    return {3'h5, c, 2'h0, ad[8], rw};
  endfunction
  function automatic logic [23:0] wdc(input logic [1:0] s);
    case (s)
      2'h0: return 24'(WL);
      2'h1: return 24'(WM);
      2'h2: return 24'(WS);
      default: return 24'h00_0000;
    endcase
  endfunction
  task automatic wr(input logic c, input logic [8:0] ad, input int n, output logic ak);
    logic r;
    m.sta;
    m.wb(slv(c, ad, 1'b0), r);
    chk("slave_ack", r, 1'b1);
    m.wb(ad[7:0], r);
    chk("word_ack", r, 1'b1);
    ak = r;
    for (int i = 0; i < n; i++) m.wb(dq[i], ak);
    m.sto;
  endtask
  task automatic rd(input logic c, input logic [8:0] ad, input int n);
    logic r;
    m.sta;
    m.wb(slv(c, ad, 1'b0), r);
    m.wb(ad[7:0], r);
    m.sta;
    m.wb(slv(c, ad, 1'b1), r);
    for (int i = 0; i < n; i++) m.rb(i < n - 1, rq[i]);
    m.sto;
  endtask
  task automatic cw(input logic [7:0] v);
    dq = '{v};
    wr(1'b1, CTRL_ADDR, 1, a);
    chk("ctl_ack", a, 1'b1);
  endtask
  task automatic cr(input logic [7:0] e);
    rd(1'b1, CTRL_ADDR, 1);
    chk("ctl", rq[0], e);
  endtask
  // Start lands inside the store, so the slave byte must go unanswered
  task automatic nvw;
    logic r;
    repeat (3) @(posedge i_mclk);
    #5;
    chk("busy_on", o_busy, 1'b1);
    m.sta;
    m.wb(slv(1'b0, 9'h000, 1'b0), r);
    m.sto;
    chk("busy_nack", r, 1'b0);
    repeat (4) @(posedge i_mclk);
    #5;
    chk("busy_off", o_busy, 1'b0);
  endtask
  initial begin
    logic [7:0] v;
    logic [4:0] pg;
    for (int i = 0; i < 512; i++) mem[i] = MEM_ERASED;
    void'($urandom(32'hA77A_4520));
    repeat (4) @(posedge i_mclk);
    #5;
    i_rst_n = 1'b1;
    repeat (4) @(posedge i_mclk);
    #5;
    chk("wd_en", wd_en, 1'b0);
    m.wb(slv(1'b0, 9'h000, 1'b0), a);
    m.sto;
    chk("no_start", a, 1'b0);
    m.sta;
    m.wb(8'hA4, a);
    m.sto;
    chk("bad_slave", a, 1'b0);
    dq = '{8'h5A};
    wr(1'b0, 9'h010, 1, a);
    chk("wel_clear", a, 1'b0);
    rd(1'b0, 9'h010, 1);
    chk("no_write", rq[0], MEM_ERASED);
    cr(CTRL_RESET);
    cw(CMD_SET_WEL);
    cr(8'h62);
    for (int k = 0; k < 4; k++) begin
      v = {1'b0, 2'(2 + 3 * k), 2'h0, k == 0, 2'h2};
      cw(CMD_SET_BOTH);
      if (k == 0) cr(8'h66);
      cw(v);
      nvw;
      cr(v);
      chk("wd_en", wd_en, v[6:5] != 2'h3);
      chk("wd_cyc", wd_cyc, wdc(v[6:5]));
    end
    cw(8'h0A);
    cr(8'h62);
    dq = '{CMD_SET_BOTH, CMD_SET_BOTH};
    wr(1'b1, CTRL_ADDR, 2, a);
    chk("second_byte", a, 1'b0);
    cr(8'h62);
    dq = '{CMD_SET_WEL};
    wr(1'b1, 9'h1FE, 1, a);
    chk("ctl_addr", a, 1'b0);
    pg = 5'($urandom_range(0, 23));
    dq = {};
    for (int i = 0; i < 20; i++) dq.push_back(8'($urandom));
    wr(1'b0, {pg, 4'hA}, 20, a);
    chk("page_ack", a, 1'b1);
    nvw;
    for (int i = 0; i < 20; i++) mem[{pg, 4'(10 + i)}] = dq[i];
    dq = {};
    wr(1'b0, {pg, 4'h3}, 0, a);
    repeat (4) @(posedge i_mclk);
    #5;
    chk("early_stop", o_busy, 1'b0);
    rd(1'b0, {pg, 4'h0}, 16);
    for (int i = 0; i < 16; i++) chk("page", rq[i], mem[{pg, 4'(i)}]);
    cw(CMD_SET_BOTH);
    cw(8'h6E);
    nvw;
    dq = '{8'h33};
    wr(1'b0, 9'h180, 1, a);
    chk("protect", a, 1'b0);
    cr(8'h6A);
    wr(1'b0, 9'h17F, 1, a);
    chk("below", a, 1'b1);
    nvw;
    mem[9'h17F] = 8'h33;
    rd(1'b0, 9'h17F, 2);
    chk("lo", rq[0], mem[9'h17F]);
    chk("hi", rq[1], mem[9'h180]);
    wrap_up;
  end
endmodule
